// *** logic/ccs_clock_source_cycler.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "ccs_defines.svh"
// Notes on behaviour
// (RL1) Each accepted press advances source: fast osc, main crystal, sub crystal, repeat.
// (RL2) With fast oscillator selected, main crystal is stopped.
// (RL3) With main crystal selected, fast oscillator is stopped.
// (RL4) With sub crystal selected, main crystal and fast oscillator are stopped.
// (RL5) Sub crystal stays enabled at all times.
// (RL6) LED toggles every 0.5 s, 1 s or 2 s by active source.
// (RL7) Falling edge of button input starts the change sequence.
// (RL8) A 12-bit interval count waits out chatter before accepting press.
// (RL9) Blink timer follows the selected clock and drives a dedicated LED bit.
// (RL10) Switch only after target is stable; stop others after switch-over is confirmed.
module ccs_clock_source_cycler #(
    parameter int unsigned BLINK_FAST_CYC = `CCS_BLINK_FAST_MS * `CCS_REF_CLK_MHZ * 1000,
    parameter int unsigned BLINK_MAIN_CYC = `CCS_BLINK_MAIN_MS * `CCS_REF_CLK_MHZ * 1000,
    parameter int unsigned BLINK_SUB_CYC = `CCS_BLINK_SUB_MS * `CCS_REF_CLK_MHZ * 1000,
    parameter logic [`CCS_TICK_W-1:0] DEB_TICK_CYC =
        `CCS_TICK_W'(`CCS_DEB_TICK_US * `CCS_REF_CLK_MHZ)
) (
    input wire logic i_ref_clk,
    input wire logic i_rst_b,
    input wire logic i_button_irq_input_b,
    input wire logic i_fast_osc_stable,
    input wire logic i_main_xtal_stable,
    input wire logic [1:0] i_clk_sel_status,
    output logic o_fast_osc_en,
    output logic o_main_xtal_en,
    output logic o_sub_xtal_en,
    output logic [1:0] o_clk_sel,
    output logic o_busy,
    output logic o_led_output_bit
);

    // ---------------------------------------------------------------
    // Declarations
    // ---------------------------------------------------------------
    logic [1:0] btn_sync_reg;
    logic btn_prev_reg;
    logic [1:0] fast_sync_reg;
    logic [1:0] main_sync_reg;
    logic [1:0] sel0_sync_reg;
    logic [1:0] sel1_sync_reg;
    logic [`CCS_TICK_W-1:0] tick_cnt_reg;
    logic [`CCS_TICK_W-1:0] deb_cnt_reg;
    logic fast_en_reg;
    logic main_en_reg;
    logic [1:0] clk_sel_reg;
    ccs_pkg::ccs_state_t state_reg;
    ccs_pkg::ccs_state_t state_next;
    ccs_pkg::ccs_src_t cur_src_reg;
    ccs_pkg::ccs_src_t tgt_src_reg;
    logic btn_fall;
    logic tick;
    logic tgt_stable;
    logic [1:0] sel_status;
    ccs_blink_if bif ();

    function automatic ccs_pkg::ccs_src_t next_src(input ccs_pkg::ccs_src_t s);
        case (s)
            ccs_pkg::CCS_SRC_FAST: next_src = ccs_pkg::CCS_SRC_MAIN;
            ccs_pkg::CCS_SRC_MAIN: next_src = ccs_pkg::CCS_SRC_SUB;
            default: next_src = ccs_pkg::CCS_SRC_FAST;
        endcase
    endfunction

    function automatic logic [1:0] sel_code(input ccs_pkg::ccs_src_t s);
        case (s)
            ccs_pkg::CCS_SRC_FAST: sel_code = `CCS_SEL_FAST;
            ccs_pkg::CCS_SRC_MAIN: sel_code = `CCS_SEL_MAIN;
            default: sel_code = `CCS_SEL_SUB;
        endcase
    endfunction

    // ---------------------------------------------------------------
    // Input synchronisers
    // ---------------------------------------------------------------
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_b) begin
            btn_sync_reg <= 2'h3;
            fast_sync_reg <= 2'h0;
            main_sync_reg <= 2'h0;
            sel0_sync_reg <= 2'h0;
            sel1_sync_reg <= 2'h0;
        end else begin
            btn_sync_reg <= {btn_sync_reg[0], i_button_irq_input_b};
            fast_sync_reg <= {fast_sync_reg[0], i_fast_osc_stable};
            main_sync_reg <= {main_sync_reg[0], i_main_xtal_stable};
            sel0_sync_reg <= {sel0_sync_reg[0], i_clk_sel_status[0]};
            sel1_sync_reg <= {sel1_sync_reg[0], i_clk_sel_status[1]};
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_b) begin
            btn_prev_reg <= 1'b1;
        end else begin
            btn_prev_reg <= btn_sync_reg[1];
        end
    end

    assign btn_fall = btn_prev_reg && !btn_sync_reg[1]; // RL7
    assign sel_status = {sel1_sync_reg[1], sel0_sync_reg[1]};

    always_comb begin
        case (tgt_src_reg)
            ccs_pkg::CCS_SRC_FAST: tgt_stable = fast_sync_reg[1];
            ccs_pkg::CCS_SRC_MAIN: tgt_stable = main_sync_reg[1];
            default: tgt_stable = 1'b1;
        endcase
    end

    // ---------------------------------------------------------------
    // Debounce interval timer
    // ---------------------------------------------------------------
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_b || state_reg != ccs_pkg::CCS_ST_DEBOUNCE) begin
            tick_cnt_reg <= `CCS_DEB_ZERO;
        end else if (tick) begin
            tick_cnt_reg <= `CCS_DEB_ZERO;
        end else begin
            tick_cnt_reg <= tick_cnt_reg + `CCS_TICK_W'd1;
        end
    end

    assign tick = tick_cnt_reg == DEB_TICK_CYC - `CCS_TICK_W'd1;

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_b || state_reg != ccs_pkg::CCS_ST_DEBOUNCE) begin
            deb_cnt_reg <= `CCS_DEB_ZERO;
        end else if (tick) begin
            deb_cnt_reg <= deb_cnt_reg + `CCS_TICK_W'd1; // RL8
        end
    end

    // ---------------------------------------------------------------
    // Change sequencer
    // ---------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ccs_pkg::CCS_ST_IDLE: begin
                if (btn_fall) begin
                    state_next = ccs_pkg::CCS_ST_DEBOUNCE; // RL7
                end
            end
            ccs_pkg::CCS_ST_DEBOUNCE: begin
                if (deb_cnt_reg == `CCS_DEB_COUNT) begin
                    state_next = btn_sync_reg[1] ? ccs_pkg::CCS_ST_IDLE
                                                 : ccs_pkg::CCS_ST_START_OSC; // RL8
                end
            end
            ccs_pkg::CCS_ST_START_OSC: begin
                if (tgt_stable) begin
                    state_next = ccs_pkg::CCS_ST_SWITCH; // RL10
                end
            end
            ccs_pkg::CCS_ST_SWITCH: begin
                if (sel_status == sel_code(tgt_src_reg)) begin
                    state_next = ccs_pkg::CCS_ST_STOP; // RL10
                end
            end
            ccs_pkg::CCS_ST_STOP: state_next = ccs_pkg::CCS_ST_IDLE;
            default: state_next = ccs_pkg::CCS_ST_IDLE;
        endcase
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_b) begin
            state_reg <= ccs_pkg::CCS_ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_b) begin
            tgt_src_reg <= ccs_pkg::CCS_SRC_FAST;
        end else if (state_reg == ccs_pkg::CCS_ST_DEBOUNCE) begin
            tgt_src_reg <= next_src(cur_src_reg); // RL1
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_b) begin
            clk_sel_reg <= `CCS_SEL_FAST;
            cur_src_reg <= ccs_pkg::CCS_SRC_FAST;
        end else if (state_reg == ccs_pkg::CCS_ST_START_OSC && tgt_stable) begin
            clk_sel_reg <= sel_code(tgt_src_reg); // RL10
            cur_src_reg <= tgt_src_reg; // RL1
        end
    end

    // ---------------------------------------------------------------
    // Oscillator enables
    // ---------------------------------------------------------------
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_b) begin
            fast_en_reg <= 1'b1;
            main_en_reg <= 1'b0; // RL2
        end else if (state_reg == ccs_pkg::CCS_ST_START_OSC) begin
            if (tgt_src_reg == ccs_pkg::CCS_SRC_FAST) begin
                fast_en_reg <= 1'b1;
            end
            if (tgt_src_reg == ccs_pkg::CCS_SRC_MAIN) begin
                main_en_reg <= 1'b1;
            end
        end else if (state_reg == ccs_pkg::CCS_ST_STOP) begin
            case (cur_src_reg)
                ccs_pkg::CCS_SRC_FAST: main_en_reg <= 1'b0; // RL2
                ccs_pkg::CCS_SRC_MAIN: fast_en_reg <= 1'b0; // RL3
                default: begin
                    fast_en_reg <= 1'b0; // RL4
                    main_en_reg <= 1'b0; // RL4
                end
            endcase
        end
    end

    // ---------------------------------------------------------------
    // Blink timer
    // ---------------------------------------------------------------
    assign bif.src = cur_src_reg; // RL9

    ccs_blink_timer #(
        .FAST_CYC(`CCS_BLINK_W'(BLINK_FAST_CYC)), // RL6
        .MAIN_CYC(`CCS_BLINK_W'(BLINK_MAIN_CYC)),
        .SUB_CYC(`CCS_BLINK_W'(BLINK_SUB_CYC))
    ) u_blink (
        .i_ref_clk(i_ref_clk),
        .i_rst_b(i_rst_b),
        .bif(bif)
    );

    assign o_fast_osc_en = fast_en_reg;
    assign o_main_xtal_en = main_en_reg;
    assign o_sub_xtal_en = 1'b1; // RL5
    assign o_clk_sel = clk_sel_reg;
    assign o_busy = state_reg != ccs_pkg::CCS_ST_IDLE;
    assign o_led_output_bit = bif.led; // RL9
endmodule
`default_nettype wire

// *** logic/ccs_defines.svh ***
`ifndef CCS_DEFINES_SVH
`define CCS_DEFINES_SVH

// ---------------------------------------------------------------
// Clock and timing
// ---------------------------------------------------------------
`define CCS_REF_CLK_MHZ 100
`define CCS_BLINK_FAST_MS 500
`define CCS_BLINK_MAIN_MS 1000
`define CCS_BLINK_SUB_MS 2000
`define CCS_DEB_TICK_US 10
`define CCS_DEB_COUNT 12'h3e8
`define CCS_DEB_ZERO 12'h000
`define CCS_BLINK_W 28
`define CCS_TICK_W 12

// ---------------------------------------------------------------
// Clock select encodings
// ---------------------------------------------------------------
`define CCS_SEL_FAST 2'h0
`define CCS_SEL_MAIN 2'h1
`define CCS_SEL_SUB 2'h2

`endif

// *** logic/ccs_pkg.sv ***
package ccs_pkg;
    typedef enum logic [1:0] {
        CCS_SRC_FAST,
        CCS_SRC_MAIN,
        CCS_SRC_SUB
    } ccs_src_t;

    typedef enum logic [2:0] {
        CCS_ST_IDLE,
        CCS_ST_DEBOUNCE,
        CCS_ST_START_OSC,
        CCS_ST_SWITCH,
        CCS_ST_STOP
    } ccs_state_t;
endpackage

// *** logic/ccs_blink_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface ccs_blink_if;
    ccs_pkg::ccs_src_t src;
    logic led;

    modport ctrl (
        output src,
        input led
    );
    modport timer (
        input src,
        output led
    );
endinterface
`default_nettype wire

// *** logic/ccs_blink_timer.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "ccs_defines.svh"
module ccs_blink_timer #(
    parameter logic [`CCS_BLINK_W-1:0] FAST_CYC = `CCS_BLINK_W'd50000000,
    parameter logic [`CCS_BLINK_W-1:0] MAIN_CYC = `CCS_BLINK_W'd100000000,
    parameter logic [`CCS_BLINK_W-1:0] SUB_CYC = `CCS_BLINK_W'd200000000
) (
    input wire logic i_ref_clk,
    input wire logic i_rst_b,
    ccs_blink_if.timer bif
);
    logic [`CCS_BLINK_W-1:0] cnt_reg;
    logic [`CCS_BLINK_W-1:0] limit;
    logic led_reg;
    ccs_pkg::ccs_src_t src_reg;

    // ---------------------------------------------------------------
    // Interval per running source
    // ---------------------------------------------------------------
    always_comb begin
        case (bif.src)
            ccs_pkg::CCS_SRC_FAST: limit = FAST_CYC;
            ccs_pkg::CCS_SRC_MAIN: limit = MAIN_CYC;
            ccs_pkg::CCS_SRC_SUB: limit = SUB_CYC;
            default: limit = FAST_CYC;
        endcase
    end

    // ---------------------------------------------------------------
    // Interval counter, restarted on a source change
    // ---------------------------------------------------------------
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_b) begin
            cnt_reg <= '0;
            src_reg <= ccs_pkg::CCS_SRC_FAST;
        end else begin
            src_reg <= bif.src;
            if (src_reg != bif.src || cnt_reg >= limit - `CCS_BLINK_W'd1) begin
                cnt_reg <= '0;
            end else begin
                cnt_reg <= cnt_reg + `CCS_BLINK_W'd1;
            end
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_b) begin
            led_reg <= 1'b0;
        end else if (src_reg == bif.src && cnt_reg >= limit - `CCS_BLINK_W'd1) begin
            led_reg <= ~led_reg; // RL6
        end
    end

    assign bif.led = led_reg;
endmodule
`default_nettype wire

// *** testbench/ccs_far_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module ccs_far_model (
    input wire logic i_ref_clk,
    input wire logic i_press,
    input wire logic i_fast_en,
    input wire logic i_main_en,
    input wire logic [1:0] i_sel,
    output logic o_btn_b,
    output logic o_fast_ok,
    output logic o_main_ok,
    output logic [1:0] o_status
);
    logic pressed_reg = 1'b0;
    logic [2:0] bounce_reg = 3'h0;
    logic [3:0] fast_reg = 4'h0;
    logic [3:0] main_reg = 4'h0;
    logic [1:0] status_reg = 2'h0;
    // ----
    // Chattering switch, pull-up when released
    // ----
    always_ff @(posedge i_ref_clk) begin
        pressed_reg <= i_press;
        if (i_press && !pressed_reg) begin
            bounce_reg <= 3'h6;
        end else if (bounce_reg != 3'h0) begin
            bounce_reg <= bounce_reg - 3'h1;
        end
    end
    assign o_btn_b = (bounce_reg != 3'h0) ? bounce_reg[0] : !pressed_reg;
    // Oscillators settle 8 cycles after enable
    always_ff @(posedge i_ref_clk) begin
        fast_reg <= (i_fast_en !== 1'b1) ? 4'h0 : fast_reg + {3'h0, !fast_reg[3]};
        main_reg <= (i_main_en !== 1'b1) ? 4'h0 : main_reg + {3'h0, !main_reg[3]};
    end
    assign o_fast_ok = fast_reg[3];
    assign o_main_ok = main_reg[3];
    // Mux follows only onto a running source
    always_ff @(posedge i_ref_clk) begin
        if (i_sel == 2'h2 || (i_sel == 2'h0 && o_fast_ok) || (i_sel == 2'h1 && o_main_ok)) begin
            status_reg <= i_sel;
        end
    end
    assign o_status = status_reg;
endmodule
`default_nettype wire

// *** testbench/ccs_cycler_asserts.sv ***
`timescale 1ns/1ps
`default_nettype none
module ccs_cycler_asserts #(
    parameter int unsigned BLINK_FAST_CYC = 50,
    parameter int unsigned BLINK_MAIN_CYC = 100,
    parameter int unsigned BLINK_SUB_CYC = 200,
    parameter int unsigned DEB_TICK_CYC = 1000
) (
    input wire logic i_ref_clk,
    input wire logic i_rst_b,
    input wire logic i_button_irq_input_b,
    input wire logic i_fast_osc_stable,
    input wire logic i_main_xtal_stable,
    input wire logic [1:0] i_clk_sel_status,
    input wire logic o_fast_osc_en,
    input wire logic o_main_xtal_en,
    input wire logic o_sub_xtal_en,
    input wire logic [1:0] o_clk_sel,
    input wire logic o_busy,
    input wire logic o_led_output_bit
);
    logic [20:0] deb_reg;
    logic [27:0] led_reg;
    int unsigned per;
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_b);
    // ----
    // Wait and blink counters
    // ----
    always_ff @(posedge i_ref_clk) begin
        deb_reg <= o_busy ? deb_reg + 21'h1 : 21'h0;
    end
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_b || $changed(o_led_output_bit) || $changed(o_clk_sel)) begin
            led_reg <= 28'h1;
        end else begin
            led_reg <= led_reg + 28'h1;
        end
    end
    assign per = (o_clk_sel == 2'h1) ? BLINK_MAIN_CYC :
                 (o_clk_sel == 2'h2) ? BLINK_SUB_CYC : BLINK_FAST_CYC;
    chk_sub_always_on: assert property (o_sub_xtal_en)
        else $error("sub crystal stopped");
    chk_fast_stops_main: assert property (!o_busy && o_clk_sel == 2'h0 |-> !o_main_xtal_en)
        else $error("main crystal running on fast source");
    chk_main_stops_fast: assert property (!o_busy && o_clk_sel == 2'h1 |-> !o_fast_osc_en)
        else $error("fast oscillator running on main source");
    chk_sub_stops_both: assert property (!o_busy && o_clk_sel == 2'h2 |->
        !o_fast_osc_en && !o_main_xtal_en)
        else $error("fast sources running on sub source");
    chk_sel_order: assert property ($changed(o_clk_sel) |-> o_clk_sel ==
        (($past(o_clk_sel) == 2'h2) ? 2'h0 : $past(o_clk_sel) + 2'h1))
        else $error("source order broken");
    chk_target_stable: assert property ($changed(o_clk_sel) |-> o_clk_sel == 2'h2 ||
        (o_clk_sel == 2'h1 ? $past(i_main_xtal_stable, 2) : $past(i_fast_osc_stable, 2)))
        else $error("switched to unsettled source");
    chk_stop_after_switch: assert property ($fell(o_fast_osc_en) || $fell(o_main_xtal_en) |->
        $past(i_clk_sel_status, 2) == o_clk_sel)
        else $error("source stopped before switch-over");
    chk_press_to_busy: assert property (!o_busy && $fell(i_button_irq_input_b) |-> ##[2:6] o_busy)
        else $error("press not taken");
    chk_deb_wait: assert property ($changed(o_clk_sel) || $changed(o_main_xtal_en) ||
        $changed(o_fast_osc_en) |-> deb_reg >= 21'(DEB_TICK_CYC * 1000))
        else $error("change before chatter wait");
    chk_led_period: assert property ($changed(o_led_output_bit) && !$changed(o_clk_sel) |->
        led_reg + 28'h1 >= per && led_reg <= per + 1)
        else $error("blink interval wrong");
    cover property ($changed(o_clk_sel) && o_clk_sel == 2'h1);
    cover property ($changed(o_clk_sel) && o_clk_sel == 2'h2);
    cover property ($changed(o_clk_sel) && o_clk_sel == 2'h0);
endmodule
bind ccs_clock_source_cycler ccs_cycler_asserts #(.BLINK_FAST_CYC(BLINK_FAST_CYC),
    .BLINK_MAIN_CYC(BLINK_MAIN_CYC), .BLINK_SUB_CYC(BLINK_SUB_CYC),
    .DEB_TICK_CYC(DEB_TICK_CYC)) i_chk (
    .i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .i_button_irq_input_b(i_button_irq_input_b),
    .i_fast_osc_stable(i_fast_osc_stable), .i_main_xtal_stable(i_main_xtal_stable),
    .i_clk_sel_status(i_clk_sel_status), .o_fast_osc_en(o_fast_osc_en),
    .o_main_xtal_en(o_main_xtal_en), .o_sub_xtal_en(o_sub_xtal_en), .o_clk_sel(o_clk_sel),
    .o_busy(o_busy), .o_led_output_bit(o_led_output_bit));
`default_nettype wire

// *** testbench/tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic i_ref_clk = 1'b0;
    logic i_rst_b = 1'b0;
    logic press = 1'b0;
    logic btn_b, fast_ok, main_ok, fast_en, main_en, sub_en, busy, led;
    logic [1:0] status, sel;
    int error_cnt = 0;
    int total_checks = 0;
    always #5 i_ref_clk = ~i_ref_clk;
    ccs_clock_source_cycler #(.BLINK_FAST_CYC(50), .BLINK_MAIN_CYC(100), .BLINK_SUB_CYC(200),
        .DEB_TICK_CYC(12'h002)) i_dut (
        .i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .i_button_irq_input_b(btn_b),
        .i_fast_osc_stable(fast_ok), .i_main_xtal_stable(main_ok), .i_clk_sel_status(status),
        .o_fast_osc_en(fast_en), .o_main_xtal_en(main_en), .o_sub_xtal_en(sub_en),
        .o_clk_sel(sel), .o_busy(busy), .o_led_output_bit(led));
    ccs_far_model i_far (.i_ref_clk(i_ref_clk), .i_press(press), .i_fast_en(fast_en),
        .i_main_en(main_en), .i_sel(sel), .o_btn_b(btn_b), .o_fast_ok(fast_ok),
        .o_main_ok(main_ok), .o_status(status));
    // ----
    // Scenarios
    // ----
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    task automatic stop_test();
        $display("Checks %0d, errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic t_reset();
        @(negedge i_ref_clk);
        check({fast_en, main_en, sub_en, sel, busy, led}, 32'h50);
    endtask
    task automatic t_blink(input int per);
        int n;
        logic prev;
        for (int k = 0; k < 2; k++) begin
            prev = led;
            n = 0;
            while (led === prev && n < 1000) begin
                @(negedge i_ref_clk);
                n++;
            end
        end
        check(n, per);
    endtask
    task automatic t_press(input logic hold, input logic [1:0] exp_sel, input logic [1:0] exp_en);
        int n;
        logic [1:0] old_sel;
        old_sel = sel;
        @(posedge i_ref_clk) press <= 1'b1;
        n = 0;
        while (busy !== 1'b1 && n < 20) begin
            @(negedge i_ref_clk);
            n++;
        end
        check(busy, 32'h1);
        repeat (1900) @(negedge i_ref_clk);
        check({busy, sel}, {1'b1, old_sel});
        if (!hold) begin
            @(posedge i_ref_clk) press <= 1'b0;
        end
        n = 0;
        while (busy !== 1'b0 && n < 200000) begin
            @(negedge i_ref_clk);
            n++;
        end
        check({sel, fast_en, main_en, sub_en}, {exp_sel, exp_en, 1'b1});
        @(posedge i_ref_clk) press <= 1'b0;
    endtask
    initial begin
        repeat (4) @(posedge i_ref_clk);
        i_rst_b <= 1'b1;
        t_reset();
        t_blink(50);
        t_press(1'b1, 2'h1, 2'h1);
        t_blink(100);
        t_press(1'b1, 2'h2, 2'h0);
        t_blink(200);
        t_press(1'b0, 2'h2, 2'h0);
        t_press(1'b1, 2'h0, 2'h2);
        t_blink(50);
        stop_test();
    end
    // Four presses of about 2000 cycles each plus blinks, with margin
    initial begin
        #300000;
        error_cnt++;
        stop_test();
    end
endmodule
`default_nettype wire
